// ==== logic/pot_status_lock_flags.sv ====
// Status register and lock gating of a dual network digital potentiometer.
// Assumes a serial decoder that hands over one command per valid pulse,
// an EEPROM controller on the same clock, and an asynchronous shutdown pin.
//
// Contract
// - Write-active flag follows non-volatile programming, two clocks behind the busy input.
// - While write-active, only addresses 00h, 01h, 04h, 05h are accepted.
// - Network-1 lock refuses wiper-1 writes and its terminal-control bits.
// - Network-0 lock refuses wiper-0 writes and its terminal-control bits.
// - Only high-voltage commands change lock state, not serial commands.
// - Network-1 lock flag shows result of last programming of its lock bit.
// - After power-on or brown-out, network-1 lock loads from stored bit.
// - Shutdown flag reads 1 while the shutdown pin is low.
// - In shutdown, terminal A is disconnected and wiper tied to terminal B.
// - Serial command interface keeps working during hardware shutdown.
// - Status flags are read-only; serial writes do not change them.
`timescale 1ns/1ps

`include "pot_status_regs.svh"

module pot_status_lock_flags (
    // Clock and reset; reset stands for power-on or brown-out.
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    // Decoded serial command.
    input wire pot_status_pkg::cmd_s CMD_I,
    // EEPROM controller.
    input wire logic NV_WRITE_BUSY_I,
    input wire logic [1:0] NV_LOCK_BITS_I,
    input wire pot_status_pkg::lock_prog_s LOCK_PROG0_I,
    input wire pot_status_pkg::lock_prog_s LOCK_PROG1_I,
    input wire logic PROTECT_FLAG_I,
    // Shutdown pin, active low, asynchronous.
    input wire logic POWER_DOWN_N_I,
    // Command answer.
    output logic CMD_ACK_O,
    output logic CMD_ERR_O,
    output logic [8:0] RD_DATA_O,
    output logic [7:0] TC_WR_MASK_O,
    output logic [1:0] WIPER_WR_EN_O,
    // Status and terminal forcing.
    output logic [8:0] POT_STATUS_O,
    output logic [1:0] TERM_A_OPEN_O,
    output logic [1:0] WIPER_TO_B_O
);

    logic [1:0] lock;
    logic pin_meta;
    logic pin_sync;
    logic next_pin_meta;
    logic next_pin_sync;

    logic nv_write_active;
    logic next_nv_write_active;
    logic power_down_pin_flag;
    logic next_power_down_pin_flag;
    logic [8:0] pot_status;
    logic [8:0] next_pot_status;
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [8:0] rd_data;
    logic [8:0] next_rd_data;
    logic [7:0] tc_mask;
    logic [7:0] next_tc_mask;
    logic [1:0] wiper_en;
    logic [1:0] next_wiper_en;
    logic [1:0] term_a_open;
    logic [1:0] next_term_a_open;
    logic [1:0] wiper_to_b;
    logic [1:0] next_wiper_to_b;

    // Programming results indexed by network for the loop below.
    pot_status_pkg::lock_prog_s prog [2];

    assign prog[0] = LOCK_PROG0_I;
    assign prog[1] = LOCK_PROG1_I;

    // Lock flags change only through the programming path or the reset reload, never here.
    for (genvar n = 0; n < 2; n++) begin : g_lock
        nv_lock_cell u_cell (
            .clk_i(CLK_SYS_I),
            .srst_i(SRST_I),
            .nv_bit_i(NV_LOCK_BITS_I[n]),
            .prog_i(prog[n]),
            .lock_o(lock[n])
        );
    end

    // Two-stage synchroniser for the shutdown pin; only the second stage
    // is read by the logic below.
    always_comb begin
        next_pin_meta = POWER_DOWN_N_I;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // Status flags, rebuilt every cycle from system state only.
    // The status word lags the flags by one clock; serial writes never reach it.
    always_comb begin
        next_nv_write_active = NV_WRITE_BUSY_I;
        next_power_down_pin_flag = ~pin_sync;
        next_pot_status = '0;
        next_pot_status[`ST_RSVD_MSB:`ST_RSVD_LSB] = `ST_RSVD_VALUE;
        next_pot_status[`ST_NV_ACTIVE_BIT] = nv_write_active;
        next_pot_status[`ST_LOCK_NET1_BIT] = lock[1];
        next_pot_status[`ST_LOCK_NET0_BIT] = lock[0];
        next_pot_status[`ST_POWER_DOWN_BIT] = power_down_pin_flag;
        next_pot_status[`ST_PROTECT_BIT] = PROTECT_FLAG_I;
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            nv_write_active <= 1'b0;
            power_down_pin_flag <= 1'b0;
            pot_status <= {`ST_RSVD_VALUE, 5'h00};
        end else begin
            nv_write_active <= next_nv_write_active;
            power_down_pin_flag <= next_power_down_pin_flag;
            pot_status <= next_pot_status;
        end
    end

    // Shutdown forcing uses the registered flag, so the terminals and the
    // status bit change on the same clock edge.
    always_comb begin
        next_term_a_open = {2{power_down_pin_flag}};
        next_wiper_to_b = {2{power_down_pin_flag}};
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            term_a_open <= 2'h0;
            wiper_to_b <= 2'h0;
        end else begin
            term_a_open <= next_term_a_open;
            wiper_to_b <= next_wiper_to_b;
        end
    end

    // Command checking; it ignores shutdown so the port keeps serving.
    // Every decision uses the flags as registered at the taking edge, so a
    // flag that changes in the same cycle applies to the next command.
    always_comb begin
        logic modify;
        logic vol_addr;
        modify = CMD_I.op != pot_status_pkg::OP_READ;
        vol_addr = CMD_I.addr == `ADDR_WIPER0_VOL ||
                   CMD_I.addr == `ADDR_WIPER1_VOL ||
                   CMD_I.addr == `ADDR_TERM_CTRL ||
                   CMD_I.addr == `ADDR_POT_STATUS;
        next_ack = CMD_I.valid;
        next_err = 1'b0;
        next_rd_data = rd_data;
        next_tc_mask = 8'h00;
        next_wiper_en = 2'h0;
        if (CMD_I.valid) begin
            if (nv_write_active && !vol_addr) begin
                next_err = 1'b1;
            end else if (CMD_I.addr > `ADDR_POT_STATUS) begin
                next_err = 1'b1;
            end else if (!modify) begin
                next_rd_data = (CMD_I.addr == `ADDR_POT_STATUS) ?
                               pot_status : `RD_DATA_RESET;
            end else begin
                unique case (CMD_I.addr)
                    `ADDR_WIPER0_VOL, `ADDR_WIPER0_NV: begin
                        next_err = lock[0];
                        next_wiper_en[0] = ~lock[0];
                    end
                    `ADDR_WIPER1_VOL, `ADDR_WIPER1_NV: begin
                        next_err = lock[1];
                        next_wiper_en[1] = ~lock[1];
                    end
                    `ADDR_TERM_CTRL: begin
                        next_tc_mask = (lock[0] ? 8'h00 : `TC_NET0_MASK) |
                                       (lock[1] ? 8'h00 : `TC_NET1_MASK);
                        next_err = lock[0] | lock[1];
                    end
                    default: begin
                        next_err = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            ack <= 1'b0;
            err <= 1'b0;
            rd_data <= `RD_DATA_RESET;
            tc_mask <= 8'h00;
            wiper_en <= 2'h0;
        end else begin
            ack <= next_ack;
            err <= next_err;
            rd_data <= next_rd_data;
            tc_mask <= next_tc_mask;
            wiper_en <= next_wiper_en;
        end
    end

    assign CMD_ACK_O = ack;
    assign CMD_ERR_O = err;
    assign RD_DATA_O = rd_data;
    assign TC_WR_MASK_O = tc_mask;
    assign WIPER_WR_EN_O = wiper_en;
    assign POT_STATUS_O = pot_status;
    assign TERM_A_OPEN_O = term_a_open;
    assign WIPER_TO_B_O = wiper_to_b;

endmodule

// ==== logic/pot_status_regs.svh ====
// Offsets, field positions, reset values and counts of the status block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef POT_STATUS_REGS_SVH
`define POT_STATUS_REGS_SVH

// Serial memory map of the device.
`define ADDR_WIPER0_VOL 4'h0
`define ADDR_WIPER1_VOL 4'h1
`define ADDR_WIPER0_NV 4'h2
`define ADDR_WIPER1_NV 4'h3
`define ADDR_TERM_CTRL 4'h4
`define ADDR_POT_STATUS 4'h5

// Field positions of pot_status.
`define ST_PROTECT_BIT 0
`define ST_POWER_DOWN_BIT 1
`define ST_LOCK_NET0_BIT 2
`define ST_LOCK_NET1_BIT 3
`define ST_NV_ACTIVE_BIT 4
`define ST_RSVD_LSB 5
`define ST_RSVD_MSB 8
`define ST_RSVD_VALUE 4'hf
`define ST_WIDTH 9

// Terminal control: network 0 in bits 3:0, network 1 in bits 7:4.
`define TC_NET_BITS 4
`define TC_WIDTH 8
`define TC_NET0_MASK 8'h0f
`define TC_NET1_MASK 8'hf0

// Command port reset value of the read data.
`define RD_DATA_RESET 9'h000

`endif

// ==== logic/pot_status_pkg.sv ====
// Types shared by the status and lock flag logic.
// Assumes the constants of pot_status_regs.svh.
`include "pot_status_regs.svh"

package pot_status_pkg;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_INCR,
        OP_DECR
    } cmd_op_e;

    // One decoded serial command, valid for a single clock.
    typedef struct packed {
        logic valid;
        cmd_op_e op;
        logic [3:0] addr;
        logic [8:0] data;
    } cmd_s;

    // Result of one programming cycle on a non-volatile lock bit.
    typedef struct packed {
        logic done;
        logic value;
    } lock_prog_s;

endpackage

// ==== logic/nv_lock_cell.sv ====
// One lock flag of a resistor network, mirroring its non-volatile bit.
// Assumes the programming result arrives on the system clock.
`timescale 1ns/1ps

module nv_lock_cell (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Stored non-volatile lock bit and programming result.
    input wire logic nv_bit_i,
    input wire pot_status_pkg::lock_prog_s prog_i,
    // Lock flag.
    output logic lock_o
);

    logic lock;
    logic next_lock;

    always_comb begin
        next_lock = lock;
        if (prog_i.done) begin
            next_lock = prog_i.value;
        end
    end

    // Reset stands for a power-on or brown-out event and reloads the bit.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock <= nv_bit_i;
        end else begin
            lock <= next_lock;
        end
    end

    assign lock_o = lock;

endmodule

// ==== testbench/pot_status_properties.sv ====
// Port assertions of the status and lock flag block.
// Assumes a bind onto pot_status_lock_flags, one clock domain.
`timescale 1ns/1ps

module pot_status_checker (
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire pot_status_pkg::cmd_s CMD_I,
    input wire logic NV_WRITE_BUSY_I,
    input wire pot_status_pkg::lock_prog_s LOCK_PROG0_I,
    input wire pot_status_pkg::lock_prog_s LOCK_PROG1_I,
    input wire logic POWER_DOWN_N_I,
    input wire logic CMD_ACK_O,
    input wire logic CMD_ERR_O,
    input wire logic [1:0] WIPER_WR_EN_O,
    input wire logic [8:0] POT_STATUS_O,
    input wire logic [1:0] TERM_A_OPEN_O,
    input wire logic [1:0] WIPER_TO_B_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SRST_I);
    a_ack_timing: assert property (CMD_ACK_O == $past(CMD_I.valid))
        else $error("Answer not one cycle after command.");
    a_power_down_flag: assert property (
        !POWER_DOWN_N_I [*5] |-> POT_STATUS_O[1])
        else $error("Shutdown flag missing.");
    a_power_up_flag: assert property (
        POWER_DOWN_N_I [*5] |-> !POT_STATUS_O[1])
        else $error("Shutdown flag stuck.");
    a_term_forced: assert property (
        TERM_A_OPEN_O == {2{POT_STATUS_O[1]}}
        && WIPER_TO_B_O == TERM_A_OPEN_O)
        else $error("Terminal forcing wrong.");
    a_rsvd_ones: assert property (POT_STATUS_O[8:5] == 4'hf)
        else $error("Reserved bits not ones.");
    a_nv_flag: assert property (
        POT_STATUS_O[4] == $past(NV_WRITE_BUSY_I, 2))
        else $error("Write-active flag wrong.");
    a_lock1_prog: assert property (LOCK_PROG1_I.done |-> ##2
        POT_STATUS_O[3] == $past(LOCK_PROG1_I.value, 2))
        else $error("Network 1 lock flag stale.");
    a_lock0_prog: assert property (LOCK_PROG0_I.done |-> ##2
        POT_STATUS_O[2] == $past(LOCK_PROG0_I.value, 2))
        else $error("Network 0 lock flag stale.");
    a_lock1_refuse: assert property (
        CMD_I.valid && (CMD_I.addr == 4'h1 || CMD_I.addr == 4'h3)
        && CMD_I.op != pot_status_pkg::OP_READ
        && POT_STATUS_O[3] && !$past(LOCK_PROG1_I.done)
        |=> CMD_ERR_O && !WIPER_WR_EN_O[1])
        else $error("Locked wiper 1 write taken.");
    a_lock0_refuse: assert property (
        CMD_I.valid && (CMD_I.addr == 4'h0 || CMD_I.addr == 4'h2)
        && CMD_I.op != pot_status_pkg::OP_READ
        && POT_STATUS_O[2] && !$past(LOCK_PROG0_I.done)
        |=> CMD_ERR_O && !WIPER_WR_EN_O[0])
        else $error("Locked wiper 0 write taken.");
    a_busy_refuse: assert property (
        CMD_I.valid && $past(NV_WRITE_BUSY_I) && !$past(SRST_I)
        && (CMD_I.addr == 4'h2 || CMD_I.addr == 4'h3)
        |=> CMD_ERR_O && WIPER_WR_EN_O == 2'h0)
        else $error("Command taken during write cycle.");
    a_status_ro: assert property (
        CMD_I.valid && CMD_I.addr == 4'h5
        && CMD_I.op != pot_status_pkg::OP_READ |=> CMD_ERR_O)
        else $error("Status write taken.");
    c_power_down_read: cover property (CMD_I.valid && !POWER_DOWN_N_I);
    c_prog: cover property (LOCK_PROG1_I.done);
    c_refused: cover property (CMD_ACK_O && CMD_ERR_O);
endmodule

bind pot_status_lock_flags pot_status_checker i_chk (.CLK_SYS_I(CLK_SYS_I),
    .SRST_I(SRST_I), .CMD_I(CMD_I), .NV_WRITE_BUSY_I(NV_WRITE_BUSY_I),
    .LOCK_PROG0_I(LOCK_PROG0_I), .LOCK_PROG1_I(LOCK_PROG1_I),
    .POWER_DOWN_N_I(POWER_DOWN_N_I), .CMD_ACK_O(CMD_ACK_O),
    .CMD_ERR_O(CMD_ERR_O), .WIPER_WR_EN_O(WIPER_WR_EN_O),
    .POT_STATUS_O(POT_STATUS_O), .TERM_A_OPEN_O(TERM_A_OPEN_O),
    .WIPER_TO_B_O(WIPER_TO_B_O));

// ==== testbench/host_model.sv ====
// Host side model issuing one decoded serial command at a time.
// Assumes the block takes a command on the rising clock edge.
`timescale 1ns/1ps

module host_model (
    input wire logic clk_i,
    output pot_status_pkg::cmd_s cmd_o
);
    initial cmd_o = '0;
    task automatic send(input pot_status_pkg::cmd_op_e op,
            input logic [3:0] a);
        @(posedge clk_i);
        cmd_o <= {1'b1, op, a, 9'h000};
        @(posedge clk_i);
        cmd_o <= '0;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench of the status and lock flag block.
// Assumes host_model drives the command port.
`timescale 1ns/1ps

module tb_top;
    logic clk, srst, busy, pin_n;
    logic [1:0] nv_bits, wen, a_open, w_b;
    pot_status_pkg::lock_prog_s prog0, prog1;
    pot_status_pkg::cmd_s cmd;
    logic ack, err, wp;
    logic [8:0] rd, status;
    logic [7:0] mask;
    int fail_count = 0;
    int comparisons = 0;

    host_model i_host (.clk_i(clk), .cmd_o(cmd));
    pot_status_lock_flags i_dut (.CLK_SYS_I(clk), .SRST_I(srst), .CMD_I(cmd),
        .NV_WRITE_BUSY_I(busy), .NV_LOCK_BITS_I(nv_bits), .LOCK_PROG0_I(prog0),
        .LOCK_PROG1_I(prog1), .PROTECT_FLAG_I(wp), .POWER_DOWN_N_I(pin_n),
        .CMD_ACK_O(ack), .CMD_ERR_O(err), .RD_DATA_O(rd), .TC_WR_MASK_O(mask),
        .WIPER_WR_EN_O(wen), .POT_STATUS_O(status), .TERM_A_OPEN_O(a_open),
        .WIPER_TO_B_O(w_b));

    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    task automatic go(input pot_status_pkg::cmd_op_e op, input logic [3:0] a,
            input logic e);
        i_host.send(op, a);
        #1;
        chk({7'h00, ack, err}, {7'h00, 1'b1, e});
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatched %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        srst = 1'b1;
        busy = 1'b0;
        pin_n = 1'b1;
        wp = 1'b0;
        nv_bits = 2'b10;
        prog0 = '0;
        prog1 = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1e8);
        $display("test reload done");
        go(pot_status_pkg::OP_WRITE, 4'h1, 1'b1);
        chk({7'h00, wen}, 9'h000);
        go(pot_status_pkg::OP_INCR, 4'h0, 1'b0);
        chk({7'h00, wen}, 9'h001);
        go(pot_status_pkg::OP_WRITE, 4'h4, 1'b1);
        chk({1'b0, mask}, 9'h00f);
        go(pot_status_pkg::OP_WRITE, 4'h5, 1'b1);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1e8);
        go(pot_status_pkg::OP_READ, 4'h0, 1'b0);
        chk(rd, 9'h000);
        go(pot_status_pkg::OP_WRITE, 4'h6, 1'b1);
        $display("test locks done");
        @(posedge clk);
        prog1 <= 2'b10;
        prog0 <= 2'b11;
        @(posedge clk);
        prog1 <= '0;
        prog0 <= '0;
        repeat (2) @(posedge clk);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1e4);
        go(pot_status_pkg::OP_DECR, 4'h3, 1'b0);
        go(pot_status_pkg::OP_WRITE, 4'h2, 1'b1);
        go(pot_status_pkg::OP_INCR, 4'h0, 1'b1);
        chk({7'h00, wen}, 9'h000);
        go(pot_status_pkg::OP_WRITE, 4'h4, 1'b1);
        chk({1'b0, mask}, 9'h0f0);
        $display("test program done");
        @(posedge clk);
        busy <= 1'b1;
        wp <= 1'b1;
        repeat (3) @(posedge clk);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1f5);
        chk(status, 9'h1f5);
        go(pot_status_pkg::OP_READ, 4'h2, 1'b1);
        go(pot_status_pkg::OP_WRITE, 4'h1, 1'b0);
        @(posedge clk);
        busy <= 1'b0;
        wp <= 1'b0;
        pin_n <= 1'b0;
        $display("test busy done");
        repeat (4) @(posedge clk);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1e6);
        chk({5'h00, a_open, w_b}, 9'h00f);
        chk(status, 9'h1e6);
        $display("test shutdown done");
        @(posedge clk);
        srst <= 1'b1;
        pin_n <= 1'b1;
        nv_bits <= 2'b00;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        go(pot_status_pkg::OP_WRITE, 4'h4, 1'b0);
        chk({1'b0, mask}, 9'h0ff);
        go(pot_status_pkg::OP_READ, 4'h5, 1'b0);
        chk(rd, 9'h1e0);
        chk(status, 9'h1e0);
        $display("test reset done");
        close_out();
    end
endmodule
